// *** hdl/cdchc_cfg.svh ***
`ifndef CDCHC_CFG_SVH
`define CDCHC_CFG_SVH
// ----------------------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------------------
`define CDCHC_RW_BIT       7
`define CDCHC_RAM_SEL_BIT  4
`define CDCHC_CT_LOCAL     2'h0
`define CDCHC_CT_GLOBAL    2'h1
`define CDCHC_CT_BAD       2'h2
`define CDCHC_CT_RAM       2'h3
// ----------------------------------------------------------------------------
// Registers, memories and identity
// ----------------------------------------------------------------------------
// Identity byte value is arbitrary
`define CDCHC_ID_CODE      8'h5A
`define CDCHC_CPE_ADDR     5'h05
`define CDCHC_CPE_RESET    8'h00
`define CDCHC_COE_BLOCKS   4'h5
`define CDCHC_LAST_WORD    3'h7
`define CDCHC_COE_WORDS    40
`define CDCHC_COE_WIDTH    14
`define CDCHC_FSK_WORDS    32
`define CDCHC_FSK_WIDTH    16
`define CDCHC_CHANNELS     4
`endif

// *** hdl/cdchc_pkg.sv ***
package cdchc_pkg;
    typedef enum logic [3:0] {
        ST_CMD  = 4'b0001,
        ST_WR   = 4'b0010,
        ST_RD   = 4'b0100,
        ST_SKIP = 4'b1000
    } cdchc_state_type;

    typedef enum logic [1:0] {
        K_LOCAL  = 2'b00,
        K_SHARED = 2'b01,
        K_COE    = 2'b10,
        K_FSK    = 2'b11
    } cdchc_kind_type;

    typedef struct packed {
        logic       rw;
        logic [1:0] ctype;
        logic [4:0] addr;
    } cdchc_cmd_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       shared;
        logic [4:0] addr;
        logic [3:0] chan;
        logic [7:0] wdata;
    } cdchc_reg_req_type;
endpackage

// *** hdl/cdchc_ram.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Simple dual-port memory, registered read
// ----------------------------------------------------------------------------
module cdchc_ram #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32,
    parameter int AW    = 6
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rdata;

    // Out-of-range read returns zero rather than X
    always_comb begin
        next_rdata = '0;
        if (int'(raddr_i) < DEPTH) begin
            next_rdata = mem[raddr_i];
        end
    end

    // Array has no reset; contents are undefined until written
    always_ff @(posedge sys_clk_i) begin
        if (we_i && (int'(waddr_i) < DEPTH)) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= next_rdata;
        end
    end
endmodule

// *** hdl/cdchc_top.sv ***
`timescale 1ns/1ns
`include "cdchc_cfg.svh"
module cdchc_top
    import cdchc_pkg::*;
(
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        cs_b_i,
    input  wire logic                        byte_stb_i,
    input  wire logic [7:0]                  byte_i,
    input  wire logic [7:0]                  reg_rdata_i,
    output logic      [7:0]                  tx_byte_o,
    output logic                             tx_valid_o,
    output cdchc_pkg::cdchc_reg_req_type     reg_req_o,
    output logic      [3:0]                  chan_enable_o
);
    import cdchc_pkg::*;

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    // Rejects the forbidden type, absent coefficient blocks and stray bits
    function automatic logic cmd_legal(input cdchc_cmd_type c);
        logic ok;
        ok = 1'b1;
        if (c.ctype == `CDCHC_CT_BAD) begin
            ok = 1'b0;
        end else if (c.ctype == `CDCHC_CT_RAM) begin
            if (!c.addr[`CDCHC_RAM_SEL_BIT]) begin
                ok = (c.addr[3:0] < `CDCHC_COE_BLOCKS);
            end else begin
                ok = (c.addr[3:2] == 2'b00);
            end
        end
        return ok;
    endfunction

    function automatic cdchc_kind_type cmd_kind(input cdchc_cmd_type c);
        cdchc_kind_type k;
        k = K_LOCAL;
        if (c.ctype == `CDCHC_CT_GLOBAL) begin
            k = K_SHARED;
        end else if (c.ctype == `CDCHC_CT_RAM) begin
            k = c.addr[`CDCHC_RAM_SEL_BIT] ? K_FSK : K_COE;
        end
        return k;
    endfunction

    // Lowest enabled channel serves reads; host keeps one enabled
    function automatic logic [1:0] low_chan(input logic [3:0] en);
        logic [1:0] ch;
        ch = 2'd0;
        if (en[0]) begin
            ch = 2'd0;
        end else if (en[1]) begin
            ch = 2'd1;
        end else if (en[2]) begin
            ch = 2'd2;
        end else if (en[3]) begin
            ch = 2'd3;
        end
        return ch;
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    cdchc_state_type   state,      next_state;
    cdchc_kind_type    kind,       next_kind;
    cdchc_reg_req_type next_req;
    logic [5:0]        cur_addr,   next_cur_addr;
    logic [2:0]        cnt,        next_cnt;
    logic              hi,         next_hi;
    logic [7:0]        hi_byte,    next_hi_byte;
    logic [7:0]        cpe,        next_cpe;
    logic [7:0]        reg_hold,   next_reg_hold;
    logic              rd_pend,    next_rd_pend;
    logic              coe_we,     next_coe_we;
    logic              fsk_we,     next_fsk_we;
    logic [5:0]        mem_waddr,  next_mem_waddr;
    logic [15:0]       mem_wdata,  next_mem_wdata;
    logic [7:0]        next_tx_byte;
    logic              next_tx_valid;
    cdchc_cmd_type     cmd_in;
    logic              take;
    logic [15:0]       mem_rword;
    logic [`CDCHC_COE_WIDTH-1:0] coe_rd [`CDCHC_CHANNELS];
    logic [`CDCHC_FSK_WIDTH-1:0] fsk_rd;
    logic [`CDCHC_CHANNELS-1:0]  coe_lane_we;

    assign cmd_in    = cdchc_cmd_type'(byte_i);
    assign take      = byte_stb_i && !cs_b_i;
    // Low coefficient bits carry no data on read-back
    assign mem_rword = (kind == K_COE) ? {coe_rd[low_chan(cpe[3:0])], 2'b00} : fsk_rd;

    // ------------------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------------------
    // One coefficient store per channel; writes fan out to enabled lanes
    for (genvar ch = 0; ch < `CDCHC_CHANNELS; ch++) begin : g_coe
        assign coe_lane_we[ch] = coe_we && cpe[ch];
        cdchc_ram #(
            .WIDTH (`CDCHC_COE_WIDTH),
            .DEPTH (`CDCHC_COE_WORDS),
            .AW    (6)
        ) u_coe (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .we_i      (coe_lane_we[ch]),
            .waddr_i   (mem_waddr),
            .wdata_i   (mem_wdata[15:2]),
            .raddr_i   (cur_addr),
            .rdata_o   (coe_rd[ch])
        );
    end

    // Single message store shared by all channels
    cdchc_ram #(
        .WIDTH (`CDCHC_FSK_WIDTH),
        .DEPTH (`CDCHC_FSK_WORDS),
        .AW    (5)
    ) u_fsk (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .we_i      (fsk_we),
        .waddr_i   (mem_waddr[4:0]),
        .wdata_i   (mem_wdata),
        .raddr_i   (cur_addr[4:0]),
        .rdata_o   (fsk_rd)
    );

    // ------------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------------
    // Next-value logic for the whole sequencer
    always_comb begin
        next_state     = state;
        next_kind      = kind;
        next_cur_addr  = cur_addr;
        next_cnt       = cnt;
        next_hi        = hi;
        next_hi_byte   = hi_byte;
        next_cpe       = cpe;
        next_req       = reg_req_o;
        next_req.wr    = 1'b0;
        next_req.rd    = 1'b0;
        next_coe_we    = 1'b0;
        next_fsk_we    = 1'b0;
        next_mem_waddr = mem_waddr;
        next_mem_wdata = mem_wdata;
        next_tx_byte   = tx_byte_o;
        next_tx_valid  = tx_valid_o;
        next_rd_pend   = reg_req_o.rd;
        next_reg_hold  = reg_hold;
        // Enable register is answered locally, the external bus is ignored
        if (rd_pend) begin
            next_reg_hold = (reg_req_o.shared && reg_req_o.addr == `CDCHC_CPE_ADDR)
                            ? cpe : reg_rdata_i;
        end
        if (cs_b_i) begin
            // Release ends any burst; completed items are already committed
            next_state    = ST_CMD;
            next_tx_valid = 1'b0;
        end else if (byte_stb_i) begin
            case (state)
                ST_CMD: begin
                    next_kind = cmd_kind(cmd_in);
                    next_hi   = 1'b1;
                    if (!cmd_legal(cmd_in)) begin
                        next_state = ST_SKIP;
                    end else begin
                        if (cmd_in.ctype == `CDCHC_CT_RAM) begin
                            next_cnt = `CDCHC_LAST_WORD;
                            if (cmd_in.addr[`CDCHC_RAM_SEL_BIT]) begin
                                next_cur_addr = {1'b0, cmd_in.addr[1:0], `CDCHC_LAST_WORD};
                            end else begin
                                next_cur_addr = {cmd_in.addr[2:0], `CDCHC_LAST_WORD};
                            end
                        end else begin
                            next_cur_addr = {1'b0, cmd_in.addr};
                            next_cnt      = {1'b0, cmd_in.addr[1:0]};
                        end
                        if (cmd_in.rw) begin
                            next_state = ST_WR;
                        end else begin
                            next_state    = ST_RD;
                            next_tx_byte  = `CDCHC_ID_CODE;
                            next_tx_valid = 1'b1;
                            next_req.rd   = (cmd_in.ctype != `CDCHC_CT_RAM);
                            next_req.addr = cmd_in.addr;
                            next_req.shared = (cmd_in.ctype == `CDCHC_CT_GLOBAL);
                            next_req.chan = cpe[3:0];
                        end
                    end
                end
                ST_WR: begin
                    if (kind == K_LOCAL || kind == K_SHARED) begin
                        if (kind == K_SHARED && cur_addr[4:0] == `CDCHC_CPE_ADDR) begin
                            next_cpe = byte_i;
                        end else begin
                            next_req.wr     = 1'b1;
                            next_req.shared = (kind == K_SHARED);
                            next_req.chan   = cpe[3:0];
                            next_req.addr   = cur_addr[4:0];
                            next_req.wdata  = byte_i;
                        end
                        next_cur_addr = cur_addr - 6'd1;
                        next_cnt      = cnt - 3'd1;
                        if (cnt == 3'd0) begin
                            next_state = ST_SKIP;
                        end
                    end else if (hi) begin
                        // High byte waits; a lone high byte never reaches memory
                        next_hi_byte = byte_i;
                        next_hi      = 1'b0;
                    end else begin
                        next_mem_wdata = {hi_byte, byte_i};
                        next_mem_waddr = cur_addr;
                        next_coe_we    = (kind == K_COE);
                        next_fsk_we    = (kind == K_FSK);
                        next_hi        = 1'b1;
                        next_cur_addr  = cur_addr - 6'd1;
                        next_cnt       = cnt - 3'd1;
                        if (cnt == 3'd0) begin
                            next_state = ST_SKIP;
                        end
                    end
                end
                ST_RD: begin
                    if (kind == K_LOCAL || kind == K_SHARED) begin
                        next_tx_byte = reg_hold;
                        if (cnt == 3'd0) begin
                            next_state = ST_SKIP;
                        end else begin
                            next_cur_addr = cur_addr - 6'd1;
                            next_cnt      = cnt - 3'd1;
                            next_req.rd   = 1'b1;
                            next_req.addr = cur_addr[4:0] - 5'd1;
                        end
                    end else if (hi) begin
                        next_tx_byte = mem_rword[15:8];
                        next_hi      = 1'b0;
                    end else begin
                        next_tx_byte = mem_rword[7:0];
                        next_hi      = 1'b1;
                        next_cur_addr = cur_addr - 6'd1;
                        next_cnt      = cnt - 3'd1;
                        if (cnt == 3'd0) begin
                            next_state = ST_SKIP;
                        end
                    end
                end
                ST_SKIP: begin
                    // Bytes past the burst end are dropped until release
                    next_tx_valid = 1'b0;
                end
                default: begin
                    next_state = ST_SKIP;
                end
            endcase
        end
    end

    // Register stage for the sequencer
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state         <= ST_CMD;
            kind          <= K_LOCAL;
            reg_req_o     <= '0;
            cur_addr      <= 6'h00;
            cnt           <= 3'h0;
            hi            <= 1'b1;
            hi_byte       <= 8'h00;
            cpe           <= `CDCHC_CPE_RESET;
            reg_hold      <= 8'h00;
            rd_pend       <= 1'b0;
            coe_we        <= 1'b0;
            fsk_we        <= 1'b0;
            mem_waddr     <= 6'h00;
            mem_wdata     <= 16'h0000;
            tx_byte_o     <= 8'h00;
            tx_valid_o    <= 1'b0;
            chan_enable_o <= 4'h0;
        end else begin
            state         <= next_state;
            kind          <= next_kind;
            reg_req_o     <= next_req;
            cur_addr      <= next_cur_addr;
            cnt           <= next_cnt;
            hi            <= next_hi;
            hi_byte       <= next_hi_byte;
            cpe           <= next_cpe;
            reg_hold      <= next_reg_hold;
            rd_pend       <= next_rd_pend;
            coe_we        <= next_coe_we;
            fsk_we        <= next_fsk_we;
            mem_waddr     <= next_mem_waddr;
            mem_wdata     <= next_mem_wdata;
            tx_byte_o     <= next_tx_byte;
            tx_valid_o    <= next_tx_valid;
            chan_enable_o <= next_cpe[3:0];
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_id_first: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_CMD && take && !cmd_in.rw && cmd_legal(cmd_in))
        |=> (tx_valid_o && tx_byte_o == `CDCHC_ID_CODE))
        else $error("identity byte not first on read");
    a_cs_abort: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        cs_b_i |=> (state == ST_CMD && !reg_req_o.wr && !coe_we && !fsk_we))
        else $error("burst not aborted by chip-select");
    a_bad_type: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_CMD && take && cmd_in.ctype == `CDCHC_CT_BAD)
        |=> (state == ST_SKIP) ##1 (!reg_req_o.wr && !coe_we && !fsk_we))
        else $error("forbidden command not ignored");
    a_burst_len: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_CMD && take && cmd_in.ctype[1] == 1'b0)
        |=> (cnt == {1'b0, $past(byte_i[1:0])} && cur_addr[4:0] == $past(byte_i[4:0])))
        else $error("register burst length wrong");
    a_addr_down: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_WR && take && kind == K_LOCAL && cnt != 3'd0)
        |=> (reg_req_o.wr && cur_addr == $past(cur_addr) - 6'd1))
        else $error("register address not stepping down");
    a_coe_start: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_CMD && take && cmd_legal(cmd_in) && cmd_kind(cmd_in) == K_COE)
        |=> (cnt == 3'd7 && cur_addr == {$past(byte_i[2:0]), 3'h7}))
        else $error("coefficient block start wrong");
    a_wr_bcast: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        coe_we |-> (coe_lane_we == chan_enable_o))
        else $error("coefficient write not broadcast");
    a_msb_first: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_WR && take && kind == K_FSK && !hi)
        |=> (fsk_we && mem_wdata == {$past(hi_byte), $past(byte_i)}))
        else $error("message word not MSB first");
    a_cpe_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == ST_WR && take && kind == K_SHARED && cur_addr[4:0] == `CDCHC_CPE_ADDR)
        |=> ##1 (chan_enable_o == $past(byte_i[3:0], 2)))
        else $error("enable register not updated");
endmodule

// *** verif/cdchc_reg_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// External register bank behind the decoder's request port
// ----------------------------------------------------------------
module cdchc_reg_model
    import cdchc_pkg::*;
(
    input  wire logic                        sys_clk_i,
    input  wire cdchc_pkg::cdchc_reg_req_type req_i,
    output logic      [7:0]                  rdata_o,
    output int                               wr_count_o,
    output logic      [3:0]                  last_chan_o
);
    logic [7:0] mem [64];
    // Distinct presets so a wrong address shows on read
    initial begin
        for (int a = 0; a < 64; a++)
            mem[a] = 8'h40 + 8'(a);
        wr_count_o = 0;
        last_chan_o = 4'h0;
        rdata_o = 8'h00;
    end
    // Shared space sits above per-channel space; data held until next read
    always @(posedge sys_clk_i) begin
        if (req_i.wr) begin
            mem[{req_i.shared, req_i.addr}] <= req_i.wdata;
            wr_count_o <= wr_count_o + 1;
            last_chan_o <= req_i.chan;
        end
        if (req_i.rd)
            rdata_o <= mem[{req_i.shared, req_i.addr}];
    end
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ns
`include "cdchc_cfg.svh"
module testbench;
    import cdchc_pkg::*;
    logic              sys_clk_i, rst_b_i, cs_b_i, byte_stb_i, tx_valid_o;
    logic [7:0]        byte_i, reg_rdata_i, tx_byte_o;
    logic [3:0]        chan_enable_o, last_chan;
    cdchc_reg_req_type reg_req_o;
    int                fail_count, n_checks, wr_count, n;
    logic [7:0]        qw[$], qe[$], qf[$];

    cdchc_top cdchc_top_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
        .byte_stb_i(byte_stb_i), .byte_i(byte_i), .reg_rdata_i(reg_rdata_i),
        .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .reg_req_o(reg_req_o),
        .chan_enable_o(chan_enable_o));
    cdchc_reg_model mdl (.sys_clk_i(sys_clk_i), .req_i(reg_req_o), .rdata_o(reg_rdata_i),
        .wr_count_o(wr_count), .last_chan_o(last_chan));

    // 100 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One byte slot; four cycles apart keeps read fetch latency met
    task automatic put(input logic [7:0] b);
        @(negedge sys_clk_i);
        byte_i = b;
        byte_stb_i = 1'b1;
        @(negedge sys_clk_i);
        byte_stb_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
    endtask

    task automatic close();
        @(negedge sys_clk_i);
        cs_b_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        chk(tx_valid_o, 1'b0);
    endtask

    task automatic wr_frame(input logic [7:0] cmd, input logic [7:0] d[$]);
        @(negedge sys_clk_i);
        cs_b_i = 1'b0;
        put(cmd);
        foreach (d[i])
            put(d[i]);
        close();
    endtask

    task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] e[$]);
        @(negedge sys_clk_i);
        cs_b_i = 1'b0;
        put(cmd);
        chk(tx_byte_o, `CDCHC_ID_CODE);
        chk(tx_valid_o, 1'b1);
        foreach (e[i]) begin
            put(8'h00);
            chk(tx_byte_o, e[i]);
        end
        close();
    endtask

    // Main sequence
    initial begin
        rst_b_i = 1'b0;
        cs_b_i = 1'b1;
        byte_stb_i = 1'b0;
        byte_i = 8'h00;
        fail_count = 0;
        n_checks = 0;
        repeat (16) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        chk(chan_enable_o, 4'h0);
        wr_frame(8'hA5, '{8'h0F});
        chk(chan_enable_o, 4'hF);
        wr_frame(8'h80, '{8'h5C});
        chk(last_chan, 4'hF);
        wr_frame(8'hA5, '{8'h01});
        rd_chk(8'h25, '{8'h01});
        // Third byte lies past the burst end
        wr_frame(8'h81, '{8'h11, 8'h22, 8'h33});
        chk(wr_count, 3);
        chk(last_chan, 4'h1);
        rd_chk(8'h03, '{8'h43, 8'h42, 8'h11, 8'h22});
        // Shared burst cut short after two registers
        wr_frame(8'hA3, '{8'hAA, 8'hBB});
        rd_chk(8'h23, '{8'hAA, 8'hBB, 8'h61, 8'h60});
        n = wr_count;
        wr_frame(8'hC1, '{8'h01, 8'h02});
        // Forbidden read type: no identity byte, output left as it was
        cs_b_i = 1'b0;
        put(8'h41);
        chk(tx_valid_o, 1'b0);
        chk(tx_byte_o, 8'h60);
        close();
        chk(wr_count, n);
        // Coefficient and message blocks, words high address first
        for (int i = 0; i < 8; i++) begin
            qw.push_back(8'h80 + 8'(i));
            qw.push_back(8'h13 + 8'(i * 32));
            qe.push_back(8'h80 + 8'(i));
            qe.push_back(8'h10 + 8'(i * 32));
            qf.push_back(8'hC0 + 8'(i));
            qf.push_back(8'h07 + 8'(i * 16));
        end
        wr_frame(8'hE1, qw);
        wr_frame(8'hF2, qf);
        rd_chk(8'h61, qe);
        rd_chk(8'h72, qf);
        // Abort leaves a lone high byte unwritten
        wr_frame(8'hE1, '{8'h55, 8'h57, 8'h66});
        qe[0] = 8'h55;
        qe[1] = 8'h54;
        rd_chk(8'h61, qe);
        rd_chk(8'h72, qf);
        results();
    end

    // Guard against a hung run
    initial begin
        #800000;
        fail_count++;
        results();
    end
endmodule
